// [hdl/eprpg_pkg.sv]
// Shared constants and types for the EPROM paged read and program logic
package eprpg_pkg;

    // Memory function command codes
    localparam logic [7:0] CMD_READ_PAGE = 8'hc3;
    localparam logic [7:0] CMD_WRITE_MEM = 8'h0f;

    // CRC-8 reflected polynomial and cleared value
    localparam logic [7:0] CRC_POLY      = 8'h8c;
    localparam logic [7:0] CRC_INIT      = 8'h00;

    // Array geometry and values
    localparam int         MEM_DEPTH     = 128;
    localparam int         ADDR_W        = 7;
    localparam logic [7:0] ERASED_BYTE   = 8'hff;
    localparam logic [4:0] PAGE_LAST     = 5'h1f;
    localparam logic [6:0] ADDR_LAST     = 7'h7f;
    localparam logic [6:0] ADDR_RESET    = 7'h00;
    localparam logic [2:0] BIT_LAST      = 3'h7;
    localparam logic [2:0] BIT_RESET     = 3'h0;
    localparam logic [2:0] ADDR_MSB_BIT  = 3'h7;

    // Command interpreter states, one-hot
    typedef enum logic [11:0] {
        ST_IDLE     = 12'h001,
        ST_CMD      = 12'h002,
        ST_ADDRL    = 12'h004,
        ST_ADDRH    = 12'h008,
        ST_DATA     = 12'h010,
        ST_CRCLD    = 12'h020,
        ST_CRCTX    = 12'h040,
        ST_PROGWAIT = 12'h080,
        ST_VERIFY   = 12'h100,
        ST_RDLD     = 12'h200,
        ST_RDDATA   = 12'h400,
        ST_DONE     = 12'h800
    } eprpg_state_t;

endpackage

// [hdl/eprpg_crc8.sv]
// Bit-serial CRC-8 generator with clear, load and shift
`timescale 1ns/1ps
module eprpg_crc8 (
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    input  wire logic       crcClear,
    input  wire logic       crcLoad,
    input  wire logic [7:0] crcLoadVal,
    input  wire logic       crcShift,
    input  wire logic       crcBit,
    output logic      [7:0] crcValue
);

    // One LSB-first step of the polynomial
    function automatic logic [7:0] crc_step(input logic [7:0] cur, input logic din);
        logic fb;
        fb = cur[0] ^ din;
        crc_step = {1'b0, cur[7:1]} ^ (fb ? eprpg_pkg::CRC_POLY : 8'h00);
    endfunction

    // Clear beats load beats shift
    always_ff @(posedge core_clk) begin
        if (sys_rst || crcClear) begin
            crcValue <= eprpg_pkg::CRC_INIT; // RULE22
        end else if (crcLoad) begin
            crcValue <= crcLoadVal; // RULE16
        end else if (crcShift) begin
            crcValue <= crc_step(crcValue, crcBit); // RULE22
        end
    end

endmodule

// [hdl/eprpg_array.sv]
// Add-only byte array: programming can only clear bits
`timescale 1ns/1ps
module eprpg_array (
    input  wire logic                          core_clk,
    input  wire logic                          sys_rst,
    input  wire logic [eprpg_pkg::ADDR_W-1:0]  rdIndex,
    output logic      [7:0]                    rdData,
    input  wire logic                          wrEn,
    input  wire logic [eprpg_pkg::ADDR_W-1:0]  wrIndex,
    input  wire logic [7:0]                    wrData
);

    logic [7:0] cells [eprpg_pkg::MEM_DEPTH];

    // Each byte ANDs in new data, zero bits program, one bits keep
    genvar gi;
    generate
        for (gi = 0; gi < eprpg_pkg::MEM_DEPTH; gi++) begin : g_cell
            always_ff @(posedge core_clk) begin
                if (sys_rst) begin
                    cells[gi] <= eprpg_pkg::ERASED_BYTE; // RULE12
                end else if (wrEn && (wrIndex == gi[eprpg_pkg::ADDR_W-1:0])) begin
                    cells[gi] <= cells[gi] & wrData; // RULE12
                end
            end
        end
    endgenerate

    // Asynchronous read by index
    assign rdData = cells[rdIndex];

endmodule

// [hdl/eprpg_core.sv]
// Memory function interpreter: paged read with CRC and byte write
`timescale 1ns/1ps
// Contract
// (RULE1) Paged read command is followed by low then high address byte.
// (RULE2) Device returns CRC-8 of command and both address bytes in eight slots.
// (RULE3) Master resets and repeats on a wrong command/address CRC.
// (RULE4) Data bytes stream from start address to end of 32-byte page.
// (RULE5) At page end device sends CRC-8 of the bytes read in that page.
// (RULE6) After page CRC, CRC restarts and reading continues at next page.
// (RULE7) After final page CRC every read slot answers one until bus reset.
// (RULE8) Bus reset aborts any command and returns to waiting for initialization.
// (RULE9) Write command takes address and data, device returns their CRC-8.
// (RULE10) Upper nine address bits forced zero, so bad addresses miscompare CRC.
// (RULE11) Master applies programming pulse only after a correct CRC.
// (RULE12) Erased memory reads ones; pulse clears bits where data is zero.
// (RULE13) After pulse device returns the addressed byte, AND of all writes.
// (RULE14) Master reprograms same address if verify shows unprogrammed zero bits.
// (RULE15) After eight verify slots the address always increments.
// (RULE16) On increment the new address low byte is loaded into the CRC.
// (RULE17) Later passes take one data byte, shift it, return the CRC.
// (RULE18) First pass CRC covers command, low address, high address, data.
// (RULE19) Master restarts write command on a wrong later-pass CRC.
// (RULE20) Device never checks CRC; it programs on every programming pulse. Here only a pulse while in ST_PROGWAIT programs; other pulses are ignored.
// (RULE21) All bytes travel least significant bit first.
// (RULE22) CRC-8 is x^8+x^5+x^4+1, LSB first, cleared at command start.
module eprpg_core (
    input  wire logic core_clk,
    input  wire logic sys_rst,
    input  wire logic cmdStart,
    input  wire logic busReset,
    input  wire logic slotWrite,
    input  wire logic slotBit,
    input  wire logic slotRead,
    input  wire logic progPulse,
    output logic      readBit,
    output logic      progArmed,
    output logic      cmdActive
);

    // All inputs come from the bus signalling logic on core_clk

    eprpg_pkg::eprpg_state_t state;
    eprpg_pkg::eprpg_state_t next_state;

    logic [2:0]                         bitCnt;
    logic [7:0]                         rxShift;
    logic [7:0]                         txShift;
    logic [eprpg_pkg::ADDR_W-1:0]       addr;
    logic [7:0]                         scratch;
    logic                               isWrite;
    logic                               pageCrc;
    logic                               lastPage;

    logic [7:0]                         crcValue;
    logic [7:0]                         memRd;

    // Phases in which write slots carry command, address or data bits
    function automatic logic rx_state(input eprpg_pkg::eprpg_state_t s);
        case (s)
            eprpg_pkg::ST_CMD,
            eprpg_pkg::ST_ADDRL,
            eprpg_pkg::ST_ADDRH,
            eprpg_pkg::ST_DATA: begin
                rx_state = 1'b1;
            end
            default: begin
                rx_state = 1'b0;
            end
        endcase
    endfunction

    // Phases in which read slots take bits from the outgoing shifter
    function automatic logic tx_state(input eprpg_pkg::eprpg_state_t s);
        case (s)
            eprpg_pkg::ST_CRCTX,
            eprpg_pkg::ST_VERIFY,
            eprpg_pkg::ST_RDDATA: begin
                tx_state = 1'b1;
            end
            default: begin
                tx_state = 1'b0;
            end
        endcase
    endfunction

    // Command byte names one of the two functions served here
    function automatic logic known_cmd(input logic [7:0] b);
        case (b)
            eprpg_pkg::CMD_READ_PAGE,
            eprpg_pkg::CMD_WRITE_MEM: begin
                known_cmd = 1'b1;
            end
            default: begin
                known_cmd = 1'b0;
            end
        endcase
    endfunction

    // State decodes
    wire inCmd      = (state == eprpg_pkg::ST_CMD);
    wire inAddrL    = (state == eprpg_pkg::ST_ADDRL);
    wire inAddrH    = (state == eprpg_pkg::ST_ADDRH);
    wire inData     = (state == eprpg_pkg::ST_DATA);
    wire inCrcLd    = (state == eprpg_pkg::ST_CRCLD);
    wire inCrcTx    = (state == eprpg_pkg::ST_CRCTX);
    wire inProgWait = (state == eprpg_pkg::ST_PROGWAIT);
    wire inVerify   = (state == eprpg_pkg::ST_VERIFY);
    wire inRdLd     = (state == eprpg_pkg::ST_RDLD);
    wire inRdData   = (state == eprpg_pkg::ST_RDDATA);
    wire inIdle     = (state == eprpg_pkg::ST_IDLE);

    // Receiving and transmitting phases
    wire rxPhase = rx_state(state);
    wire txPhase = tx_state(state);

    // Slot qualified events
    wire rxSlot   = slotWrite & rxPhase;
    wire txSlot   = slotRead & txPhase;
    wire lastBit  = (bitCnt == eprpg_pkg::BIT_LAST);
    wire byteDone = rxSlot & lastBit;
    wire txDone   = txSlot & lastBit;

    // Assembled byte, bits arrive LSB first
    wire [7:0] rxByte = {slotBit, rxShift[7:1]}; // RULE21

    // Command decodes
    wire isWriteCmd = (rxByte == eprpg_pkg::CMD_WRITE_MEM);
    wire cmdKnown   = known_cmd(rxByte); // RULE1 RULE9

    // Position in the array
    wire pageEnd = (addr[4:0] == eprpg_pkg::PAGE_LAST);
    wire addrEnd = (addr == eprpg_pkg::ADDR_LAST);
    wire [eprpg_pkg::ADDR_W-1:0] addrInc = addr + 7'h01;

    // Address bits the write path drops in truncation
    wire addrBitMasked = inAddrH | (inAddrL & (bitCnt == eprpg_pkg::ADDR_MSB_BIT));

    // CRC feed selection
    wire crcClear = (inIdle & cmdStart) | (inCrcTx & txDone & ~isWrite); // RULE22 RULE6
    wire crcLoad  = inVerify & txDone; // RULE16
    wire [7:0] crcLoadVal = {1'b0, addrInc}; // RULE16
    wire crcShift = rxSlot | (slotRead & inRdData); // RULE18 RULE17 RULE5
    wire crcBit   = inRdData ? txShift[0]
                  : ((isWrite & addrBitMasked) ? 1'b0 : slotBit); // RULE10

    // Programming takes place on any pulse while armed
    wire progWrite = inProgWait & progPulse; // RULE20

    // Verify value is the byte after this pulse is applied
    wire [7:0] verifyByte = memRd & scratch; // RULE13

    eprpg_crc8 u_crc (
        .core_clk   (core_clk),
        .sys_rst    (sys_rst),
        .crcClear   (crcClear),
        .crcLoad    (crcLoad),
        .crcLoadVal (crcLoadVal),
        .crcShift   (crcShift),
        .crcBit     (crcBit),
        .crcValue   (crcValue)
    );

    eprpg_array u_array (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .rdIndex  (addr),
        .rdData   (memRd),
        .wrEn     (progWrite),
        .wrIndex  (addr),
        .wrData   (scratch)
    );

    // Sequencing of the command phases
    always_comb begin
        next_state = state;
        case (state)
            eprpg_pkg::ST_IDLE: begin
                if (cmdStart) begin
                    next_state = eprpg_pkg::ST_CMD;
                end
            end
            eprpg_pkg::ST_CMD: begin
                if (byteDone) begin
                    if (cmdKnown) begin
                        next_state = eprpg_pkg::ST_ADDRL; // RULE1 RULE9
                    end else begin
                        next_state = eprpg_pkg::ST_DONE;
                    end
                end
            end
            eprpg_pkg::ST_ADDRL: begin
                if (byteDone) begin
                    next_state = eprpg_pkg::ST_ADDRH; // RULE1
                end
            end
            eprpg_pkg::ST_ADDRH: begin
                if (byteDone) begin
                    next_state = isWrite ? eprpg_pkg::ST_DATA : eprpg_pkg::ST_CRCLD; // RULE2 RULE9
                end
            end
            eprpg_pkg::ST_DATA: begin
                if (byteDone) begin
                    next_state = eprpg_pkg::ST_CRCLD; // RULE17
                end
            end
            eprpg_pkg::ST_CRCLD: begin
                next_state = eprpg_pkg::ST_CRCTX;
            end
            eprpg_pkg::ST_CRCTX: begin
                if (txDone) begin
                    if (isWrite) begin
                        next_state = eprpg_pkg::ST_PROGWAIT;
                    end else if (pageCrc && lastPage) begin
                        next_state = eprpg_pkg::ST_DONE; // RULE7
                    end else begin
                        next_state = eprpg_pkg::ST_RDLD; // RULE6
                    end
                end
            end
            eprpg_pkg::ST_PROGWAIT: begin
                if (progPulse) begin
                    next_state = eprpg_pkg::ST_VERIFY; // RULE20
                end
            end
            eprpg_pkg::ST_VERIFY: begin
                if (txDone) begin
                    next_state = eprpg_pkg::ST_DATA; // RULE15 RULE17
                end
            end
            eprpg_pkg::ST_RDLD: begin
                next_state = eprpg_pkg::ST_RDDATA;
            end
            eprpg_pkg::ST_RDDATA: begin
                if (txDone) begin
                    next_state = pageEnd ? eprpg_pkg::ST_CRCLD : eprpg_pkg::ST_RDLD; // RULE4 RULE5
                end
            end
            eprpg_pkg::ST_DONE: begin
                next_state = eprpg_pkg::ST_DONE; // RULE7
            end
            default: begin
                next_state = eprpg_pkg::ST_IDLE;
            end
        endcase
        if (busReset) begin
            next_state = eprpg_pkg::ST_IDLE; // RULE8
        end
    end

    // State register
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state <= eprpg_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Bit counter restarts at every phase change
    always_ff @(posedge core_clk) begin
        if (sys_rst || (next_state != state)) begin
            bitCnt <= eprpg_pkg::BIT_RESET;
        end else if (rxSlot || txSlot) begin
            bitCnt <= bitCnt + 3'h1;
        end
    end

    // Incoming bit shifter, LSB first
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rxShift <= eprpg_pkg::ERASED_BYTE;
        end else if (rxSlot) begin
            rxShift <= rxByte; // RULE21
        end
    end

    // Command kind latched from the command byte
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            isWrite <= 1'b0;
        end else if (inCmd && byteDone) begin
            isWrite <= isWriteCmd;
        end
    end

    // Address counter, seven bits kept, upper bits dropped
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            addr <= eprpg_pkg::ADDR_RESET;
        end else if (inAddrL && byteDone) begin
            addr <= rxByte[eprpg_pkg::ADDR_W-1:0]; // RULE10
        end else if ((inVerify || inRdData) && txDone) begin
            addr <= addrInc; // RULE15 RULE4
        end
    end

    // Scratchpad for the byte to be programmed
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            scratch <= eprpg_pkg::ERASED_BYTE;
        end else if (inData && byteDone) begin
            scratch <= rxByte; // RULE17
        end
    end

    // Page CRC pending and final page marks
    always_ff @(posedge core_clk) begin
        if (sys_rst || inCmd) begin
            pageCrc  <= 1'b0;
            lastPage <= 1'b0;
        end else if (inRdData && txDone && pageEnd) begin
            pageCrc  <= 1'b1; // RULE5
            lastPage <= addrEnd; // RULE7
        end
    end

    // Outgoing shifter, idle value ones so open slots read high
    always_ff @(posedge core_clk) begin
        if (sys_rst || busReset) begin
            txShift <= eprpg_pkg::ERASED_BYTE; // RULE8
        end else if (inCrcLd) begin
            txShift <= crcValue; // RULE2 RULE5 RULE9 RULE17
        end else if (inRdLd) begin
            txShift <= memRd; // RULE4
        end else if (progWrite) begin
            txShift <= verifyByte; // RULE13
        end else if (txSlot) begin
            txShift <= {1'b1, txShift[7:1]}; // RULE21 RULE7
        end
    end

    // Status flags, registered
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            progArmed <= 1'b0;
            cmdActive <= 1'b0;
        end else begin
            progArmed <= (next_state == eprpg_pkg::ST_PROGWAIT);
            cmdActive <= (next_state != eprpg_pkg::ST_IDLE);
        end
    end

    // Bit presented for the next read slot
    assign readBit = txShift[0];

endmodule

// [test/eprpg_properties.sv]
// Concurrent checks on the interpreter ports
`timescale 1ns/1ps
module eprpg_properties (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic cmdStart,
    input wire logic busReset,
    input wire logic slotWrite,
    input wire logic slotBit,
    input wire logic slotRead,
    input wire logic progPulse,
    input wire logic readBit,
    input wire logic progArmed,
    input wire logic cmdActive
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // Any input that may move the read bit
    wire logic anyEvt;
    assign anyEvt = slotRead | slotWrite | progPulse | busReset;
    sequence s_idle2;
        (!cmdActive && !progArmed) [*2];
    endsequence
    property p_abort;
        busReset |=> s_idle2;
    endproperty
    a_abort: assert property (p_abort) else $error("abort did not idle");
    property p_fall;
        $fell(cmdActive) |-> $past(busReset);
    endproperty
    a_fall: assert property (p_fall) else $error("command ended without bus reset");
    property p_idleOne;
        !cmdActive && !$past(cmdActive) |-> readBit;
    endproperty
    a_idleOne: assert property (p_idleOne) else $error("idle read bit not one");
    property p_hold;
        !$stable(readBit) |-> $past(anyEvt) || $past(anyEvt, 2);
    endproperty
    a_hold: assert property (p_hold) else $error("read bit moved without cause");
    property p_armRise;
        $rose(progArmed) |-> $past(slotRead);
    endproperty
    a_armRise: assert property (p_armRise) else $error("armed without read slot");
    property p_armHold;
        progArmed && !progPulse && !busReset |=> progArmed;
    endproperty
    a_armHold: assert property (p_armHold) else $error("armed dropped early");
    property p_armDrop;
        progArmed && progPulse |=> !progArmed;
    endproperty
    a_armDrop: assert property (p_armDrop) else $error("armed after pulse");
    property p_armAct;
        progArmed |-> cmdActive;
    endproperty
    a_armAct: assert property (p_armAct) else $error("armed while idle");
endmodule
bind eprpg_core eprpg_properties u_props (.core_clk(core_clk), .sys_rst(sys_rst), .cmdStart(cmdStart),
    .busReset(busReset), .slotWrite(slotWrite), .slotBit(slotBit), .slotRead(slotRead),
    .progPulse(progPulse), .readBit(readBit), .progArmed(progArmed), .cmdActive(cmdActive));

// [test/eprpg_master.sv]
// Bus master model issuing slot and pulse strobes
`timescale 1ns/1ps
module eprpg_master (
    input  wire logic core_clk,
    input  wire logic readBit,
    output logic      cmdStart,
    output logic      busReset,
    output logic      slotWrite,
    output logic      slotBit,
    output logic      slotRead,
    output logic      progPulse
);
    int gap = 3;
    // Idle levels at time zero
    initial begin
        {cmdStart, busReset, slotWrite, slotRead, progPulse} = 5'h00;
        slotBit = 1'b1;
    end
    // One-cycle strobe, then a gap of at least three cycles; released bit inverted
    task automatic strobe(input logic [4:0] m);
        @(negedge core_clk);
        {cmdStart, busReset, slotWrite, slotRead, progPulse} = m;
        @(negedge core_clk);
        {cmdStart, busReset, slotWrite, slotRead, progPulse} = 5'h00;
        slotBit = ~slotBit;
        repeat (gap) @(negedge core_clk);
    endtask
    // Byte out in eight write slots
    task automatic wrByte(input logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            slotBit = b[i];
            strobe(5'h04);
        end
    endtask
    // Byte in over eight read slots
    task automatic rdByte(output logic [7:0] v);
        for (int i = 0; i < 8; i++) begin
            v[i] = readBit;
            strobe(5'h02);
        end
    endtask
endmodule

// [test/eprom_page_read_and_program_tb.sv]
// Self-checking bench for the memory function interpreter
`timescale 1ns/1ps
module eprom_page_read_and_program_tb;
    logic        core_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        cmdStart, busReset, slotWrite, slotBit, slotRead, progPulse;
    logic        readBit, progArmed, cmdActive;
    logic [7:0]  mem [128];
    logic [31:0] seed = 32'h3cfb84d6;
    int          n_mismatch = 0;
    int          n_compared = 0;
    always #5 core_clk = ~core_clk;
    eprpg_core dut (.core_clk(core_clk), .sys_rst(sys_rst), .cmdStart(cmdStart), .busReset(busReset),
        .slotWrite(slotWrite), .slotBit(slotBit), .slotRead(slotRead), .progPulse(progPulse),
        .readBit(readBit), .progArmed(progArmed), .cmdActive(cmdActive));
    eprpg_master bm (.core_clk(core_clk), .readBit(readBit), .cmdStart(cmdStart), .busReset(busReset),
        .slotWrite(slotWrite), .slotBit(slotBit), .slotRead(slotRead), .progPulse(progPulse));
    // Xorshift source
    function automatic logic [7:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    // Reflected CRC-8, one byte LSB first
    function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
        for (int i = 0; i < 8; i++) begin
            c = (c >> 1) ^ ((c[0] ^ d[i]) ? eprpg_pkg::CRC_POLY : 8'h00);
        end
        return c;
    endfunction
    task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic end_sim();
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Write command; a wrong CRC makes the master reset instead of pulsing
    task automatic wrCmd(input logic [7:0] al, input logic [7:0] ah, input int n);
        logic [7:0] c, v, d, r;
        logic [6:0] a;
        a = al[6:0];
        c = crc8(crc8(crc8(8'h00, eprpg_pkg::CMD_WRITE_MEM), {1'b0, a}), 8'h00);
        bm.strobe(5'h10);
        bm.wrByte(eprpg_pkg::CMD_WRITE_MEM);
        bm.wrByte(al);
        bm.wrByte(ah);
        for (int p = 0; p <= n; p++) begin
            d = xs();
            bm.wrByte(d);
            bm.rdByte(v);
            chk("write crc", v, crc8(c, d));
            if (v !== crc8(c, d)) begin
                bm.strobe(5'h08);
                return;
            end
            r = xs();
            bm.strobe(r[4:0] & 5'h16);
            chk("armed", {7'h00, progArmed}, 8'h01);
            bm.strobe(5'h01);
            chk("disarmed", {7'h00, progArmed}, 8'h00);
            mem[a] = mem[a] & d;
            bm.rdByte(v);
            chk("verify", v, mem[a]);
            a++;
            c = {1'b0, a};
        end
        bm.strobe(5'h08);
    endtask
    // Paged read from a start address to the final page
    task automatic rdCmd(input logic [6:0] a0);
        logic [7:0] c, v, r;
        bm.strobe(5'h10);
        bm.wrByte(eprpg_pkg::CMD_READ_PAGE);
        bm.wrByte({1'b0, a0});
        bm.wrByte(8'h00);
        bm.rdByte(v);
        c = crc8(crc8(crc8(8'h00, eprpg_pkg::CMD_READ_PAGE), {1'b0, a0}), 8'h00);
        chk("command crc", v, c);
        if (v !== c) begin
            bm.strobe(5'h08);
            return;
        end
        c = 8'h00;
        for (int i = a0; i < 128; i++) begin
            bm.rdByte(v);
            chk("read data", v, mem[i]);
            c = crc8(c, mem[i]);
            if (i[4:0] == 5'h1f) begin
                bm.rdByte(v);
                chk("page crc", v, c);
                c = 8'h00;
            end
        end
        bm.rdByte(v);
        chk("tail", v, 8'hff);
        r = xs();
        bm.strobe(r[4:0] & 5'h17);
        bm.rdByte(v);
        chk("tail after refused strobes", v, 8'hff);
        bm.strobe(5'h08);
    endtask
    // Hang guard
    initial begin
        repeat (100000) @(posedge core_clk);
        n_mismatch++;
        end_sim();
    end
    // Main sequence
    initial begin
        logic [7:0] r, v;
        for (int i = 0; i < 128; i++) begin
            mem[i] = eprpg_pkg::ERASED_BYTE;
        end
        repeat (2) @(negedge core_clk);
        sys_rst = 1'b0;
        chk("idle", {6'h00, progArmed, cmdActive}, 8'h00);
        r = xs();
        wrCmd(8'hfe, r | 8'h01, 2);
        wrCmd(8'h7e, 8'h00, 0);
        for (int k = 0; k < 4; k++) begin
            r = xs();
            bm.gap = 3 + r[1:0];
            wrCmd(r, 8'h00, 1);
        end
        bm.strobe(5'h10);
        bm.wrByte(eprpg_pkg::CMD_READ_PAGE);
        bm.wrByte(8'h40);
        bm.wrByte(8'h00);
        bm.rdByte(v);
        bm.rdByte(v);
        chk("first byte", v, mem[64]);
        bm.strobe(5'h08);
        chk("aborted", {7'h00, cmdActive}, 8'h00);
        bm.strobe(5'h10);
        bm.wrByte(8'h3c);
        bm.rdByte(v);
        chk("unknown command", v, 8'hff);
        bm.strobe(5'h08);
        rdCmd(7'h1d);
        end_sim();
    end
endmodule
